// File: rfx_cfg.svh
// constants for the register frame exchange
`ifndef RFX_CFG_SVH
`define RFX_CFG_SVH
// ==========================================
// frame layout
`define RFX_TYPE_H2D     8'h27
`define RFX_TYPE_D2H     8'h34
`define RFX_FIS_DWORDS   5
`define RFX_C_BIT        15
`define RFX_I_BIT        14
// ==========================================
// status and control bits, device reset command code
`define RFX_BSY          7
`define RFX_DRQ          3
`define RFX_SERV         4
`define RFX_SRST         2
`define RFX_NIEN         1
`define RFX_CMD_DEV_RST  8'h08
// ==========================================
// reset values
`define RFX_STATUS_RST   8'h00
`define RFX_CTRL_RST     8'h00
// ==========================================
// timing
`define RFX_CLK_MHZ      200
`define RFX_BUSY_NS      400
`define RFX_BUSY_CYC     ((`RFX_BUSY_NS * `RFX_CLK_MHZ) / 1000)
// ==========================================
// shadow register select codes
`define RFX_A_FEAT       4'h1
`define RFX_A_COUNT      4'h2
`define RFX_A_LBAL       4'h3
`define RFX_A_LBAM       4'h4
`define RFX_A_LBAH       4'h5
`define RFX_A_DEV        4'h6
`define RFX_A_CMD        4'h7
`define RFX_A_CTRL       4'h8
`define RFX_A_FEAT_X     4'h9
`define RFX_A_COUNT_X    4'ha
`define RFX_A_LBAL_X     4'hb
`define RFX_A_LBAM_X     4'hc
`define RFX_A_LBAH_X     4'hd
`endif

// File: rfx_pkg.sv
// shared types for the register frame exchange
package rfx_pkg;
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] features;
    logic [7:0] features_exp;
    logic [7:0] device;
    logic [7:0] lba_low;
    logic [7:0] lba_mid;
    logic [7:0] lba_high;
    logic [7:0] lba_low_exp;
    logic [7:0] lba_mid_exp;
    logic [7:0] lba_high_exp;
    logic [7:0] count;
    logic [7:0] count_exp;
    logic [7:0] control;
  } rfx_tf_t;

  typedef enum logic {RFX_IDLE, RFX_SEND} rfx_tx_t;

  function automatic logic [7:0] rfx_fis_type(input logic [31:0] w);
    rfx_fis_type = w[7:0];
  endfunction
endpackage

// File: rfx_link_if.sv
// dword link between host adapter and drive
`timescale 1ns/1ps
interface rfx_link_if;
  logic [31:0] h2d_data;
  logic        h2d_valid;
  logic        h2d_last;
  logic        h2d_ready;
  logic [31:0] d2h_data;
  logic        d2h_valid;
  logic        d2h_last;
  logic        d2h_ready;

  modport host (output h2d_data, h2d_valid, h2d_last, input h2d_ready,
                input d2h_data, d2h_valid, d2h_last, output d2h_ready);
  modport drive (input h2d_data, h2d_valid, h2d_last, output h2d_ready,
                 output d2h_data, d2h_valid, d2h_last, input d2h_ready);
endinterface

// File: rfx_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module rfx_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output      logic         in_ready,
  // drain side
  output      logic [W-1:0] out_data,
  output      logic         out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("rfx_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  wire [AW:0] used = AW'(0) + (wr_ptr - rd_ptr);
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;

  assign in_ready  = used != (AW+1)'(DEPTH);
  assign out_valid = used != '0;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // ==========================================
  // pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // ==========================================
  // storage
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// File: rfx_host_end.sv
// host adapter end: shadow registers, frame build and frame intake
`timescale 1ns/1ps
`include "rfx_cfg.svh"

module rfx_host_end #(
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // shadow register access
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic [3:0] rd_addr,
  output      logic [7:0] rd_data,
  output      logic       intrq,
  // link
  rfx_link_if.host        link
);
  localparam logic [2:0] LAST_IDX = 3'(`RFX_FIS_DWORDS - 1);

  generate
    if (`RFX_BUSY_CYC < 1 || FIFO_DEPTH < 2) begin : g_bad
      $error("rfx_host_end timing or fifo depth out of range");
    end
  endgenerate

  // ==========================================
  // frame word builder
  function automatic logic [31:0] h2d_word(input rfx_pkg::rfx_tf_t t,
                                           input logic c,
                                           input logic [2:0] i);
    h2d_word = 32'h0;
    if (i == 3'h0) begin
      h2d_word = {t.features, t.command, c, 7'h00, `RFX_TYPE_H2D};
    end else if (i == 3'h1) begin
      h2d_word = {t.device, t.lba_high, t.lba_mid, t.lba_low};
    end else if (i == 3'h2) begin
      h2d_word = {t.features_exp, t.lba_high_exp, t.lba_mid_exp, t.lba_low_exp};
    end else if (i == 3'h3) begin
      h2d_word = {t.control, 8'h00, t.count_exp, t.count};
    end
  endfunction

  // ==========================================
  // state
  rfx_pkg::rfx_tf_t tf;
  rfx_pkg::rfx_tf_t snap;
  rfx_pkg::rfx_tx_t tx_state;
  logic [7:0]       status;
  logic [7:0]       alt_status;
  logic [7:0]       error;
  logic             pend_cmd;
  logic             pend_ctrl;
  logic             snap_c;
  logic [2:0]       tx_idx;
  logic [2:0]       rx_idx;
  logic [31:0]      rx_buf [0:3];
  logic             int_pend;
  logic [7:0]       next_status;
  logic [32:0]      fifo_out;
  logic             fifo_in_ready;

  // ==========================================
  // write decode
  wire is_cmd_wr  = wr_en && wr_addr == `RFX_A_CMD;
  wire is_ctrl_wr = wr_en && wr_addr == `RFX_A_CTRL;
  wire blocked    = status[`RFX_BSY] || status[`RFX_DRQ];
  wire dev_reset  = is_cmd_wr && wr_data == `RFX_CMD_DEV_RST;
  wire tf_wr_ok   = wr_en && !is_ctrl_wr && (!blocked || dev_reset);
  wire cmd_go     = is_cmd_wr && tf_wr_ok && !tf.control[`RFX_SRST];
  wire ctrl_go    = is_ctrl_wr && wr_data != tf.control;
  wire srst_rise  = is_ctrl_wr && wr_data[`RFX_SRST] && !tf.control[`RFX_SRST];

  // ==========================================
  // transmit control
  wire start   = tx_state == rfx_pkg::RFX_IDLE && (pend_cmd || pend_ctrl);
  wire start_c = !pend_ctrl;
  wire push    = tx_state == rfx_pkg::RFX_SEND;
  wire adv     = push && fifo_in_ready;
  wire tx_done = adv && tx_idx == LAST_IDX;
  wire [31:0] tx_word = h2d_word(snap, snap_c, tx_idx);

  // ==========================================
  // receive decode
  wire        rx_beat = link.d2h_valid && link.d2h_ready;
  wire        rx_end  = rx_beat && link.d2h_last;
  wire [31:0] w0      = rx_buf[0];
  wire [31:0] w1      = rx_buf[1];
  wire [31:0] w2      = rx_buf[2];
  wire [31:0] w3      = rx_buf[3];
  wire        rx_form = rx_idx == LAST_IDX
                        && rfx_pkg::rfx_fis_type(w0) == `RFX_TYPE_D2H;
  wire        rx_ok   = rx_end && rx_form && blocked;
  wire        stat_rd = rd_en && rd_addr == `RFX_A_CMD;
  wire        next_int = (int_pend && !stat_rd) || (rx_ok && w0[`RFX_I_BIT]);

  // ==========================================
  // read selection
  wire [7:0] rd_sel =
    rd_addr == `RFX_A_FEAT    ? error :
    rd_addr == `RFX_A_COUNT   ? tf.count :
    rd_addr == `RFX_A_LBAL    ? tf.lba_low :
    rd_addr == `RFX_A_LBAM    ? tf.lba_mid :
    rd_addr == `RFX_A_LBAH    ? tf.lba_high :
    rd_addr == `RFX_A_DEV     ? tf.device :
    rd_addr == `RFX_A_CMD     ? status :
    rd_addr == `RFX_A_CTRL    ? alt_status :
    rd_addr == `RFX_A_FEAT_X  ? tf.features_exp :
    rd_addr == `RFX_A_COUNT_X ? tf.count_exp :
    rd_addr == `RFX_A_LBAL_X  ? tf.lba_low_exp :
    rd_addr == `RFX_A_LBAM_X  ? tf.lba_mid_exp :
    rd_addr == `RFX_A_LBAH_X  ? tf.lba_high_exp : 8'h00;

  // ==========================================
  // status update, busy set wins over frame load
  always_comb begin
    next_status = status;
    if (rx_ok) next_status = w0[23:16];
    if (cmd_go || srst_rise) next_status[`RFX_BSY] = 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status     <= `RFX_STATUS_RST;
      alt_status <= `RFX_STATUS_RST;
      error      <= 8'h00;
      int_pend   <= 1'b0;
      intrq      <= 1'b0;
      rd_data    <= 8'h00;
    end else begin
      status     <= next_status;
      alt_status <= next_status;
      if (rx_ok) error <= w0[31:24];
      int_pend   <= next_int;
      intrq      <= next_int && !tf.control[`RFX_NIEN];
      if (rd_en) rd_data <= rd_sel;
    end
  end

  // ==========================================
  // shadow command block, software write wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tf         <= '0;
      tf.control <= `RFX_CTRL_RST;
    end else begin
      if (rx_ok) begin
        tf.lba_low      <= w1[7:0];
        tf.lba_mid      <= w1[15:8];
        tf.lba_high     <= w1[23:16];
        tf.device       <= w1[31:24];
        tf.lba_low_exp  <= w2[7:0];
        tf.lba_mid_exp  <= w2[15:8];
        tf.lba_high_exp <= w2[23:16];
        tf.count        <= w3[7:0];
        tf.count_exp    <= w3[15:8];
      end
      if (is_ctrl_wr) tf.control <= wr_data;
      if (tf_wr_ok) begin
        if (wr_addr == `RFX_A_FEAT) tf.features <= wr_data;
        else if (wr_addr == `RFX_A_COUNT) tf.count <= wr_data;
        else if (wr_addr == `RFX_A_LBAL) tf.lba_low <= wr_data;
        else if (wr_addr == `RFX_A_LBAM) tf.lba_mid <= wr_data;
        else if (wr_addr == `RFX_A_LBAH) tf.lba_high <= wr_data;
        else if (wr_addr == `RFX_A_DEV) tf.device <= wr_data;
        else if (wr_addr == `RFX_A_CMD) tf.command <= wr_data;
        else if (wr_addr == `RFX_A_FEAT_X) tf.features_exp <= wr_data;
        else if (wr_addr == `RFX_A_COUNT_X) tf.count_exp <= wr_data;
        else if (wr_addr == `RFX_A_LBAL_X) tf.lba_low_exp <= wr_data;
        else if (wr_addr == `RFX_A_LBAM_X) tf.lba_mid_exp <= wr_data;
        else if (wr_addr == `RFX_A_LBAH_X) tf.lba_high_exp <= wr_data;
      end
    end
  end

  // ==========================================
  // pending requests and frame sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_cmd  <= 1'b0;
      pend_ctrl <= 1'b0;
      tx_state  <= rfx_pkg::RFX_IDLE;
      tx_idx    <= 3'h0;
      snap      <= '0;
      snap_c    <= 1'b0;
    end else begin
      pend_cmd  <= (pend_cmd && !(start && start_c) && !tf.control[`RFX_SRST]) || cmd_go;
      pend_ctrl <= (pend_ctrl && !(start && !start_c)) || ctrl_go;
      case (tx_state)
        rfx_pkg::RFX_IDLE: begin
          if (start) begin
            snap     <= tf;
            snap_c   <= start_c;
            tx_idx   <= 3'h0;
            tx_state <= rfx_pkg::RFX_SEND;
          end
        end
        rfx_pkg::RFX_SEND: begin
          if (tx_done) tx_state <= rfx_pkg::RFX_IDLE;
          else if (adv) tx_idx <= tx_idx + 3'h1;
        end
        default: tx_state <= rfx_pkg::RFX_IDLE;
      endcase
    end
  end

  // ==========================================
  // receive collector
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_idx         <= 3'h0;
      link.d2h_ready <= 1'b0;
    end else begin
      link.d2h_ready <= 1'b1;
      if (rx_end) rx_idx <= 3'h0;
      else if (rx_beat && rx_idx != 3'h7) rx_idx <= rx_idx + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rx_beat && !rx_idx[2]) rx_buf[rx_idx[1:0]] <= link.d2h_data;
  end

  // ==========================================
  // outgoing frame buffer
  rfx_fifo #(.W(33), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_data   ({tx_idx == LAST_IDX, tx_word}),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (link.h2d_valid),
    .out_ready (link.h2d_ready)
  );

  assign link.h2d_data = fifo_out[31:0];
  assign link.h2d_last = fifo_out[32];
endmodule

// File: rfx_drive_end.sv
// drive end: takes host frames, returns register frames
`timescale 1ns/1ps
`include "rfx_cfg.svh"
module rfx_drive_end (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // link
  rfx_link_if.drive       link,
  // received register copy
  output rfx_pkg::rfx_tf_t tf,
  output      logic       cmd_start,
  // completion request
  input  wire logic       done_req,
  input  wire logic [7:0] done_status,
  input  wire logic [7:0] done_error,
  input  wire logic       done_intr,
  output      logic       done_ready
);
  localparam logic [2:0] LAST_IDX = 3'(`RFX_FIS_DWORDS - 1);

  function automatic logic [31:0] d2h_word(input logic [7:0] st,
                                           input logic [7:0] er,
                                           input logic ir,
                                           input rfx_pkg::rfx_tf_t t,
                                           input logic [2:0] i);
    d2h_word = 32'h0;
    if (i == 3'h0) begin
      d2h_word = {er, st, 1'b0, ir, 6'h00, `RFX_TYPE_D2H};
    end else if (i == 3'h1) begin
      d2h_word = {t.device, t.lba_high, t.lba_mid, t.lba_low};
    end else if (i == 3'h2) begin
      d2h_word = {8'h00, t.lba_high_exp, t.lba_mid_exp, t.lba_low_exp};
    end else if (i == 3'h3) begin
      d2h_word = {16'h0000, t.count_exp, t.count};
    end
  endfunction

  logic [2:0]  rx_idx;
  logic [31:0] rx_buf [0:3];
  logic        host_busy;
  logic [7:0]  snap_status;
  logic [7:0]  snap_error;
  logic        snap_intr;
  logic [2:0]  tx_idx;

  // ==========================================
  // decode
  wire        rx_beat = link.h2d_valid && link.h2d_ready;
  wire        rx_end  = rx_beat && link.h2d_last;
  wire [31:0] w0      = rx_buf[0];
  wire [31:0] w1      = rx_buf[1];
  wire [31:0] w2      = rx_buf[2];
  wire [31:0] w3      = rx_buf[3];
  wire        rx_ok   = rx_end && rx_idx == LAST_IDX
                        && rfx_pkg::rfx_fis_type(w0) == `RFX_TYPE_H2D;
  wire        srst_up = w3[24 + `RFX_SRST] && !tf.control[`RFX_SRST];
  wire        take    = done_req && done_ready;
  wire [7:0]  st_mask = host_busy ? done_status
                        : done_status & ~(8'h01 << `RFX_SERV);
  wire        idle_st = !st_mask[`RFX_BSY] && !st_mask[`RFX_DRQ];
  wire        tx_beat = link.d2h_valid && link.d2h_ready;
  wire [2:0]  tx_nxt  = tx_idx + 3'h1;

  // ==========================================
  // frame intake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_idx         <= 3'h0;
      link.h2d_ready <= 1'b0;
      tf             <= '0;
      cmd_start      <= 1'b0;
      host_busy      <= 1'b0;
    end else begin
      link.h2d_ready <= 1'b1;
      if (rx_end) rx_idx <= 3'h0;
      else if (rx_beat && rx_idx != 3'h7) rx_idx <= rx_idx + 3'h1;
      cmd_start <= rx_ok && w0[`RFX_C_BIT];
      if (rx_ok) begin
        tf <= '{command: w0[23:16], features: w0[31:24], features_exp: w2[31:24],
                device: w1[31:24], lba_low: w1[7:0], lba_mid: w1[15:8],
                lba_high: w1[23:16], lba_low_exp: w2[7:0], lba_mid_exp: w2[15:8],
                lba_high_exp: w2[23:16], count: w3[7:0], count_exp: w3[15:8],
                control: w3[31:24]};
      end
      host_busy <= (host_busy && !(take && idle_st))
                   || (rx_ok && (w0[`RFX_C_BIT] || srst_up));
    end
  end

  always_ff @(posedge clk) begin
    if (rx_beat && !rx_idx[2]) rx_buf[rx_idx[1:0]] <= link.h2d_data;
  end

  // ==========================================
  // frame send
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_ready     <= 1'b0;
      link.d2h_valid <= 1'b0;
      link.d2h_last  <= 1'b0;
      link.d2h_data  <= 32'h0;
      tx_idx         <= 3'h0;
      snap_status    <= 8'h00;
      snap_error     <= 8'h00;
      snap_intr      <= 1'b0;
    end else begin
      if (take) begin
        done_ready     <= 1'b0;
        snap_status    <= st_mask;
        snap_error     <= done_error;
        snap_intr      <= done_intr;
        tx_idx         <= 3'h0;
        link.d2h_valid <= 1'b1;
        link.d2h_last  <= 1'b0;
        link.d2h_data  <= d2h_word(st_mask, done_error, done_intr, tf, 3'h0);
      end else if (tx_beat) begin
        if (link.d2h_last) begin
          link.d2h_valid <= 1'b0;
          link.d2h_last  <= 1'b0;
          done_ready     <= 1'b1;
        end else begin
          tx_idx        <= tx_nxt;
          link.d2h_last <= tx_nxt == LAST_IDX;
          link.d2h_data <= d2h_word(snap_status, snap_error, snap_intr, tf, tx_nxt);
        end
      end else if (!link.d2h_valid) begin
        done_ready <= 1'b1;
      end
    end
  end
endmodule

// File: rfx_link_checker.sv
// assertions on the register frame link between the two ends
`timescale 1ns/1ps
module rfx_link_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // host to drive
  input wire logic [31:0] h2d_data,
  input wire logic        h2d_valid,
  input wire logic        h2d_last,
  input wire logic        h2d_ready,
  // drive to host
  input wire logic [31:0] d2h_data,
  input wire logic        d2h_valid,
  input wire logic        d2h_last,
  input wire logic        d2h_ready
);
  // ==========================================
  // beat counters
  logic [2:0] hc;
  logic [2:0] dc;
  logic       c_hold;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hc     <= 3'h0;
      dc     <= 3'h0;
      c_hold <= 1'b0;
    end else begin
      if (h2d_valid && h2d_ready) hc <= h2d_last ? 3'h0 : hc + 3'h1;
      if (d2h_valid && d2h_ready) dc <= d2h_last ? 3'h0 : dc + 3'h1;
      if (h2d_valid && h2d_ready && hc == 3'h0) c_hold <= h2d_data[15];
    end
  end

  // ==========================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_h2d_type: assert property (h2d_valid && hc == 3'h0 |-> h2d_data[7:0] == 8'h27)
    else $error("host frame type wrong");
  a_h2d_len: assert property (h2d_valid && h2d_last |-> hc == 3'h4)
    else $error("host frame length wrong");
  a_h2d_rsvd: assert property (h2d_valid && hc == 3'h0 |-> h2d_data[14:8] == 7'h00)
    else $error("host frame reserved bits set");
  a_h2d_tail: assert property (h2d_valid && hc == 3'h4 |-> h2d_data == 32'h0)
    else $error("host frame last dword not zero");
  a_cmd_srst: assert property (h2d_valid && hc == 3'h3 && c_hold |-> !h2d_data[26])
    else $error("command frame with soft reset");
  a_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("host beat changed while stalled");
  a_d2h_type: assert property (d2h_valid && dc == 3'h0 |-> d2h_data[7:0] == 8'h34)
    else $error("drive frame type wrong");
  a_d2h_len: assert property (d2h_valid && d2h_last |-> dc == 3'h4)
    else $error("drive frame length wrong");
  a_d2h_rsvd: assert property (d2h_valid && dc == 3'h0 |->
    {d2h_data[15], d2h_data[13:8]} == 7'h0)
    else $error("drive frame reserved bits set");
  a_d2h_tail: assert property (d2h_valid && dc == 3'h4 |-> d2h_data == 32'h0)
    else $error("drive frame last dword not zero");
  a_d2h_gap: assert property (d2h_valid && d2h_ready && d2h_last |=> !d2h_valid)
    else $error("drive valid held after last");
endmodule

// File: register_fis_shadow_exchange_tb_top.sv
// testbench joining host end and drive end over the frame link
`timescale 1ns/1ps
module register_fis_shadow_exchange_tb_top;
  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  logic             wr_en = 1'b0;
  logic             rd_en = 1'b0;
  logic [3:0]       wr_addr = 4'h0;
  logic [3:0]       rd_addr = 4'h0;
  logic [7:0]       wr_data = 8'h00;
  logic [7:0]       rd_data;
  logic             intrq;
  logic             done_req = 1'b0;
  logic             done_intr = 1'b0;
  logic [7:0]       done_status = 8'h00;
  logic [7:0]       done_error = 8'h00;
  logic             done_ready;
  logic             cmd_start;
  logic             rd_pend = 1'b0;
  rfx_pkg::rfx_tf_t tf;
  logic [7:0]       m [16];
  logic [7:0]       st = 8'h00;
  logic [7:0]       err = 8'h00;
  logic             pend = 1'b0;
  logic [159:0]     q [$];
  logic [7:0]       rq [$];
  logic [159:0]     fr;
  logic [3:0]       fa [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
  int               beat = 0;
  int               n_fail = 0;
  int               checked = 0;
  int               n_cmd = 0;
  int               n_cmd_exp = 0;
  integer           seed = 32'hba047ea4;

  always #2.5 clk = ~clk;

  // ==========================================
  // design and checker
  rfx_link_if link ();
  rfx_host_end #(.FIFO_DEPTH(32)) u_rfx_host_end (.clk(clk), .arst_n(arst_n), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .intrq(intrq), .link(link));
  rfx_drive_end u_rfx_drive_end (.clk(clk), .arst_n(arst_n), .link(link), .tf(tf),
    .cmd_start(cmd_start), .done_req(done_req), .done_status(done_status),
    .done_error(done_error), .done_intr(done_intr), .done_ready(done_ready));
  rfx_link_checker u_rfx_link_checker (.clk(clk), .arst_n(arst_n), .h2d_data(link.h2d_data),
    .h2d_valid(link.h2d_valid), .h2d_last(link.h2d_last), .h2d_ready(link.h2d_ready),
    .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid), .d2h_last(link.d2h_last),
    .d2h_ready(link.d2h_ready));

  // ==========================================
  // helpers
  task automatic chk(input logic [159:0] g, input logic [159:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [159:0] frame(input logic c);
    frame = {32'h0, m[8], 8'h00, m[10], m[2], m[9], m[13], m[12], m[11],
             m[6], m[5], m[4], m[3], m[1], m[7], c, 7'h00, 8'h27};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    if (a == 4'h8) begin
      if (d != m[8]) begin
        if (d[2] && !m[8][2]) st[7] = 1'b1;
        m[8] = d;
        q.push_back(frame(1'b0));
      end
    end else if (!(st[7] || st[3]) || (a == 4'h7 && d == 8'h08)) begin
      m[a] = d;
      if (a == 4'h7 && !m[8][2]) begin
        st[7] = 1'b1;
        n_cmd_exp++;
        q.push_back(frame(1'b1));
      end
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    if (a == 4'h7) pend = 1'b0;
    @(posedge clk);
  endtask

  task automatic ichk();
    repeat (3) @(posedge clk);
    chk(intrq, pend & ~m[8][1]);
  endtask

  task automatic done(input logic [7:0] s, input logic [7:0] e, input logic i);
    logic acc;
    acc = st[7] || st[3];
    done_req <= 1'b1;
    done_status <= s;
    done_error <= e;
    done_intr <= i;
    @(posedge clk);
    for (int k = 0; k < 50 && done_ready !== 1'b1; k++) @(posedge clk);
    done_req <= 1'b0;
    for (int k = 0; k < 100 && !(link.d2h_valid && link.d2h_last && link.d2h_ready); k++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    if (acc) begin
      st = s;
      err = e;
      pend = pend | i;
    end
  endtask

  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================
  // output watcher
  always @(posedge clk) rd_pend <= rd_en;

  always @(negedge clk) begin
    if (rd_pend) chk(rd_data, rq.pop_front());
    if (cmd_start === 1'b1) n_cmd++;
    if (link.h2d_valid === 1'b1 && link.h2d_ready === 1'b1) begin
      fr[beat*32 +: 32] = link.h2d_data;
      beat++;
      if (link.h2d_last) begin
        chk(beat, 5);
        chk(q.size() > 0, 1'b1);
        if (q.size() > 0) chk(fr, q.pop_front());
        beat = 0;
      end
    end
  end

  // ==========================================
  // scenarios
  initial begin
    foreach (m[i]) m[i] = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 11; i++) wr(fa[i], 8'($random(seed)));
    wr(4'h8, 8'h00);
    wr(4'h8, 8'h02);
    wr(4'h7, 8'h25);
    rd(4'h7, st);
    rd(4'h8, st);
    wr(4'h1, 8'h5a);
    done(8'h40, 8'($random(seed)), 1'b1);
    for (int i = 0; i < 11; i++) rd(fa[i], fa[i] == 4'h1 ? err : m[fa[i]]);
    rd(4'h7, st);
    rd(4'h8, st);
    wr(4'h4, 8'h77);
    ichk();
    wr(4'h8, 8'h00);
    ichk();
    rd(4'h7, st);
    ichk();
    done(8'h41, 8'h3c, 1'b1);
    rd(4'h7, st);
    rd(4'h1, err);
    wr(4'h8, 8'h04);
    rd(4'h7, st);
    wr(4'h7, 8'h08);
    wr(4'h8, 8'h00);
    done(8'h40, 8'h00, 1'b0);
    wr(4'h7, 8'($random(seed)));
    rd(4'h7, st);
    done(8'h50, 8'h00, 1'b1);
    ichk();
    rd(4'h7, st);
    ichk();
    for (int k = 0; k < 200 && q.size() > 0; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(q.size(), 0);
    chk(n_cmd, n_cmd_exp);
    chk(tf,
        {m[7], m[1], m[9], m[6], m[3], m[4], m[5], m[11], m[12], m[13], m[2], m[10], m[8]});
    conclude();
  end

  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule
